/* File: hw/fcss_pkg.sv */
/*
 Constants, field layouts and types shared by the clock source selector:
 register offsets, reset values, source codes and the operating modes.
 Assumes a 32-bit AHB-Lite fabric and registers of eight bits each.
*/
//
// Overview of operation
// - bus clock is half the clock output
// - reset enters engaged-internal mode, bus divider two
// - power-on reset loads coarse 0x80, fine 0
// - other resets keep both trim values
// - FLL reference divided by three-bit select
// - two-bit bus divider: one, two, four, eight
// - debug clock is digital oscillator divided two
// - nine trim bits tune internal reference
// - drive low-power oscillator control outputs
// - seven operating modes including stop
// - engaged-internal outputs FLL, debug from FLL
// - engaged-external outputs FLL, debug from FLL
// - bypassed-internal FLL runs, outputs internal reference
// - low-power internal bypass: FLL off, no debug
// - bypassed-external FLL runs, outputs external reference
// - low-power external bypass: FLL off, no debug
// - stop: no clocks, references kept if configured
// - source select 00 FLL, 01 internal, 10 external
// - low-power bit disables FLL in bypass modes unless debugging
// - reference select bit picks internal or external
package fcss_pkg;

   // =========================================================
   // Bus and register map
   localparam int          REG_W             = 8;
   localparam int          DATA_W            = 32;
   localparam int          PAD_W             = DATA_W - REG_W;
   localparam int          REG_AW            = 4;
   localparam int          HTRANS_ACTIVE_BIT = 1;
   localparam logic [2:0]  HSIZE_WORD        = 3'h2;
   localparam logic        HRESP_OKAY        = 1'h0;
   localparam logic [3:0]  WORD_MASK         = 4'hc;
   localparam logic [3:0]  OFS_CTRL1         = 4'h0;
   localparam logic [3:0]  OFS_CTRL2         = 4'h4;
   localparam logic [3:0]  OFS_TRIM          = 4'h8;
   localparam logic [3:0]  OFS_STATUS        = 4'hc;

   // =========================================================
   // Field layouts
   typedef struct packed {
      logic [1:0] clock_source_select;
      logic [2:0] reference_divider_select;
      logic       internal_ref_select;
      logic       internal_ref_enable;
      logic       internal_ref_stop_keep;
   } fcss_ctrl1_t;

   typedef struct packed {
      logic [1:0] bus_divider_select;
      logic       freq_range_high;
      logic       high_gain_select;
      logic       low_power_select;
      logic       oscillator_request;
      logic       external_ref_enable;
      logic       external_ref_stop_keep;
   } fcss_ctrl2_t;

   typedef struct packed {
      logic [2:0] zero;
      logic       internal_ref_active;
      logic [1:0] active_source;
      logic       oscillator_ready;
      logic       fine_trim;
   } fcss_status_t;

   typedef struct packed {
      logic high_gain_select;
      logic freq_range_high;
      logic oscillator_request;
      logic external_ref_enable;
      logic external_ref_stop_keep;
   } fcss_osc_ctrl_t;

   // =========================================================
   // Reset values
   localparam logic [7:0]  CTRL1_RESET     = 8'h04;
   localparam logic [7:0]  CTRL2_RESET     = 8'h40;
   localparam logic [7:0]  COARSE_TRIM_POR = 8'h80;
   localparam logic        FINE_TRIM_POR   = 1'h0;

   // =========================================================
   // Source codes and modes
   localparam logic [1:0]  SRC_FLL  = 2'h0;
   localparam logic [1:0]  SRC_INT  = 2'h1;
   localparam logic [1:0]  SRC_EXT  = 2'h2;
   localparam logic [1:0]  SRC_RSVD = 2'h3;
   localparam logic        REF_INT  = 1'h0;
   localparam logic        REF_EXT  = 1'h1;
   localparam int          NSRC     = 3;

   typedef enum logic [2:0] {
      fll_engaged_internal_mode,
      fll_engaged_external_mode,
      fll_bypassed_internal_mode,
      fll_bypassed_internal_lowpower_mode,
      fll_bypassed_external_mode,
      fll_bypassed_external_lowpower_mode,
      clocks_stopped_mode
   } fcss_mode_t;

endpackage : fcss_pkg

/* File: hw/fcss_edge_div.sv */
/*
 Glitch-free edge divider: picks one of several sampled source clocks and
 toggles its output every 2**div source edges. Assumes the sources are far
 slower than hclk and arrive as one-cycle edge pulses.
*/
`timescale 1ns/1ps
module fcss_edge_div #(
   parameter int NSRC  = 3,
   parameter int SEL_W = 2,
   parameter int DIV_W = 2
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic [NSRC-1:0]  src_edge,
   input  wire logic [SEL_W-1:0] sel_req,
   input  wire logic [DIV_W-1:0] div_req,
   input  wire logic             hold_req,
   output logic                  clk_out,
   output logic [SEL_W-1:0]      sel_active,
   output logic [DIV_W-1:0]      div_active,
   output logic                  held
);
   localparam int CNT_W = (2 ** DIV_W) - 1;

   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic [CNT_W-1:0] terminal;
   logic             next_clk_out;
   logic [SEL_W-1:0] next_sel_active;
   logic [DIV_W-1:0] next_div_active;
   logic             next_held;
   logic             edge_seen;

   // =========================================================
   // Next state
   always_comb begin
      edge_seen       = src_edge[sel_active] && !held;
      terminal        = CNT_W'((32'h1 << div_active) - 32'h1);
      next_cnt        = cnt;
      next_clk_out    = clk_out;
      next_sel_active = sel_active;
      next_div_active = div_active;
      next_held       = held;
      if (edge_seen) begin
         if (cnt == terminal) begin
            next_cnt     = '0;
            next_clk_out = !clk_out;
         end else begin
            next_cnt = cnt + CNT_W'(1);
         end
      end
      // Only swap at the start of a low phase, so no phase is cut short
      if (!clk_out && (cnt == '0) && !edge_seen) begin
         next_sel_active = sel_req;
         next_div_active = div_req;
         next_held       = hold_req;
      end
   end

   // =========================================================
   // Registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt        <= '0;
         clk_out    <= 1'h0;
         sel_active <= '0;
         div_active <= '0;
         held       <= 1'h0;
      end else begin
         cnt        <= next_cnt;
         clk_out    <= next_clk_out;
         sel_active <= next_sel_active;
         div_active <= next_div_active;
         held       <= next_held;
      end
   end

endmodule : fcss_edge_div

/* File: hw/fcss_clock_source.sv */
/*
 Clock source selector: AHB-Lite register slave, mode decode, FLL
 reference divider, system clock divider, bus and debug clocks, trims and
 oscillator controls. Assumes the oscillator, reference and FLL clocks
 arrive as levels synchronous to hclk and much slower than it.
*/
`timescale 1ns/1ps
module fcss_clock_source (
   input  wire logic                     hclk,
   input  wire logic                     hresetn,
   input  wire logic                     power_on_resetn,
   input  wire logic                     hsel,
   input  wire logic [31:0]              haddr,
   input  wire logic [1:0]               htrans,
   input  wire logic                     hwrite,
   input  wire logic [2:0]               hsize,
   input  wire logic [31:0]              hwdata,
   input  wire logic                     hready,
   output logic                          hreadyout,
   output logic [31:0]                   hrdata,
   output logic                          hresp,
   input  wire logic                     dco_clk,
   input  wire logic                     int_ref_clk,
   input  wire logic                     ext_ref_clk,
   input  wire logic                     stop_request,
   input  wire logic                     debug_active,
   input  wire logic                     oscillator_ready,
   output logic                          clock_output,
   output logic                          bus_clock,
   output logic                          debug_clock,
   output logic                          fll_enable,
   output logic                          fll_reference_clock,
   output logic [8:0]                    trim_value,
   output logic                          internal_ref_on,
   output fcss_pkg::fcss_osc_ctrl_t      osc_ctrl
);
   import fcss_pkg::*;

   // =========================================================
   // Declarations
   fcss_ctrl1_t         ctrl1;
   fcss_ctrl1_t         next_ctrl1;
   fcss_ctrl2_t         ctrl2;
   fcss_ctrl2_t         next_ctrl2;
   fcss_status_t        status_rd;
   fcss_mode_t          mode;
   fcss_mode_t          next_mode;
   logic [REG_W-1:0]    coarse_trim;
   logic [REG_W-1:0]    next_coarse_trim;
   logic                fine_trim;
   logic                next_fine_trim;
   logic                wr_pend;
   logic                next_wr_pend;
   logic [REG_AW-1:0]   wr_addr;
   logic [REG_AW-1:0]   next_wr_addr;
   logic [REG_AW-1:0]   rd_addr;
   logic [DATA_W-1:0]   next_hrdata;
   logic [REG_W-1:0]    rd_byte;
   logic                addr_take;
   logic [NSRC-1:0]     src_level;
   logic [NSRC-1:0]     src_q;
   logic [NSRC-1:0]     src_edge;
   logic                out_q;
   logic                next_out_q;
   logic                next_bus_clock;
   logic                next_debug_clock;
   logic                debug_on;
   logic                next_fll_enable;
   logic                run_used_int;
   logic                next_run_used_int;
   logic                next_internal_ref_on;
   fcss_osc_ctrl_t      next_osc_ctrl;
   logic [1:0]          sys_sel;
   logic [1:0]          sys_sel_active;
   logic [1:0]          sys_div_active;
   logic                sys_held;
   logic                ref_sel;
   logic                ref_sel_active;
   logic [2:0]          ref_div_active;
   logic                ref_held;
   logic                in_stop;
   logic                bypass_lp;

   // =========================================================
   // AHB-Lite slave, zero wait states, always OKAY
   assign hreadyout = 1'h1;
   assign hresp     = HRESP_OKAY;
   assign addr_take = hsel && hready && htrans[HTRANS_ACTIVE_BIT];
   assign rd_addr   = haddr[REG_AW-1:0] & WORD_MASK;

   always_comb begin
      next_wr_pend = addr_take && hwrite && (hsize == HSIZE_WORD);
      next_wr_addr = addr_take ? rd_addr : wr_addr;
      next_ctrl1   = ctrl1;
      next_ctrl2   = ctrl2;
      if (wr_pend) begin
         unique case (wr_addr)
            OFS_CTRL1: next_ctrl1 = fcss_ctrl1_t'(hwdata[REG_W-1:0]);
            OFS_CTRL2: next_ctrl2 = fcss_ctrl2_t'(hwdata[REG_W-1:0]);
            default: ;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'h0;
         wr_addr <= '0;
         ctrl1   <= fcss_ctrl1_t'(CTRL1_RESET);
         ctrl2   <= fcss_ctrl2_t'(CTRL2_RESET);
      end else begin
         wr_pend <= next_wr_pend;
         wr_addr <= next_wr_addr;
         ctrl1   <= next_ctrl1;
         ctrl2   <= next_ctrl2;
      end
   end

   // =========================================================
   // Trims live on the power-on reset only
   always_comb begin
      next_coarse_trim = coarse_trim;
      next_fine_trim   = fine_trim;
      if (wr_pend && (wr_addr == OFS_TRIM)) begin
         next_coarse_trim = hwdata[REG_W-1:0];
      end
      if (wr_pend && (wr_addr == OFS_STATUS)) begin
         next_fine_trim = hwdata[0];
      end
   end

   // Bus resets leave these untouched by design
   always_ff @(posedge hclk or negedge power_on_resetn) begin
      if (!power_on_resetn) begin
         coarse_trim <= COARSE_TRIM_POR;
         fine_trim   <= FINE_TRIM_POR;
      end else begin
         coarse_trim <= next_coarse_trim;
         fine_trim   <= next_fine_trim;
      end
   end

   assign trim_value = {coarse_trim, fine_trim};

   // =========================================================
   // Read path; uses next values so a read right after a write sees it
   always_comb begin
      status_rd.zero                = '0;
      status_rd.internal_ref_active = (ref_sel_active == REF_INT);
      status_rd.active_source       = sys_sel_active;
      status_rd.oscillator_ready    = oscillator_ready &&
                                      ctrl2.oscillator_request;
      status_rd.fine_trim           = next_fine_trim;
      unique case (rd_addr)
         OFS_CTRL1:  rd_byte = next_ctrl1;
         OFS_CTRL2:  rd_byte = next_ctrl2;
         OFS_TRIM:   rd_byte = next_coarse_trim;
         OFS_STATUS: rd_byte = status_rd;
         default:    rd_byte = '0;
      endcase
      next_hrdata = hrdata;
      if (addr_take && !hwrite) begin
         next_hrdata = {{PAD_W{1'b0}}, rd_byte};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
      end else begin
         hrdata <= next_hrdata;
      end
   end

   // =========================================================
   // Mode decode
   assign bypass_lp = ctrl2.low_power_select && !debug_active;

   always_comb begin
      unique case (ctrl1.clock_source_select)
         SRC_INT: begin
            next_mode = bypass_lp ? fll_bypassed_internal_lowpower_mode
                                  : fll_bypassed_internal_mode;
         end
         SRC_EXT: begin
            next_mode = bypass_lp ? fll_bypassed_external_lowpower_mode
                                  : fll_bypassed_external_mode;
         end
         default: begin
            // Reserved code behaves as the FLL selection
            next_mode = ctrl1.internal_ref_select
                        ? fll_engaged_internal_mode
                        : fll_engaged_external_mode;
         end
      endcase
      if (stop_request) begin
         next_mode = clocks_stopped_mode;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode <= fll_engaged_internal_mode;
      end else begin
         mode <= next_mode;
      end
   end

   assign in_stop = (mode == clocks_stopped_mode);

   // =========================================================
   // FLL enable, reference and oscillator controls
   always_comb begin
      unique case (next_mode)
         fll_engaged_internal_mode,
         fll_engaged_external_mode,
         fll_bypassed_internal_mode,
         fll_bypassed_external_mode: next_fll_enable = 1'h1;
         default:                    next_fll_enable = 1'h0;
      endcase
      next_run_used_int = run_used_int;
      if (next_mode != clocks_stopped_mode) begin
         next_run_used_int = (next_mode == fll_engaged_internal_mode) ||
            (next_mode == fll_bypassed_internal_mode) ||
            (next_mode == fll_bypassed_internal_lowpower_mode);
         next_internal_ref_on = ctrl1.internal_ref_enable ||
            next_run_used_int ||
            (next_fll_enable && ctrl1.internal_ref_select);
      end else begin
         // Kept alive in stop only when asked for
         next_internal_ref_on = ctrl1.internal_ref_stop_keep &&
            (ctrl1.internal_ref_enable || run_used_int);
      end
      next_osc_ctrl.high_gain_select       = ctrl2.high_gain_select;
      next_osc_ctrl.freq_range_high        = ctrl2.freq_range_high;
      next_osc_ctrl.oscillator_request     = ctrl2.oscillator_request;
      next_osc_ctrl.external_ref_stop_keep = ctrl2.external_ref_stop_keep;
      if (next_mode == clocks_stopped_mode) begin
         next_osc_ctrl.external_ref_enable = ctrl2.external_ref_enable &&
            ctrl2.external_ref_stop_keep;
      end else begin
         next_osc_ctrl.external_ref_enable = ctrl2.external_ref_enable ||
            (ctrl1.clock_source_select == SRC_EXT) ||
            !ctrl1.internal_ref_select;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fll_enable      <= 1'h1;
         run_used_int    <= 1'h1;
         internal_ref_on <= 1'h1;
         osc_ctrl        <= '0;
      end else begin
         fll_enable      <= next_fll_enable;
         run_used_int    <= next_run_used_int;
         internal_ref_on <= next_internal_ref_on;
         osc_ctrl        <= next_osc_ctrl;
      end
   end

   // =========================================================
   // Source edge detection; inputs are synchronous levels
   assign src_level = {ext_ref_clk, int_ref_clk, dco_clk};
   assign src_edge  = src_level ^ src_q;

   // No reset: a reset value would fake a source edge on release
   always_ff @(posedge hclk) begin
      src_q <= src_level;
   end

   // =========================================================
   // FLL reference divider, 1 to 128
   assign ref_sel = ctrl1.internal_ref_select ? REF_INT
                                              : REF_EXT;

   fcss_edge_div #(
      .NSRC  (2),
      .SEL_W (1),
      .DIV_W (3)
   ) u_ref_div (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .src_edge   ({src_edge[SRC_EXT], src_edge[SRC_INT]}),
      .sel_req    (ref_sel),
      .div_req    (ctrl1.reference_divider_select),
      .hold_req   (!fll_enable),
      .clk_out    (fll_reference_clock),
      .sel_active (ref_sel_active),
      .div_active (ref_div_active),
      .held       (ref_held)
   );

   // =========================================================
   // System clock: source select then bus divider
   assign sys_sel = (ctrl1.clock_source_select == SRC_RSVD)
                    ? SRC_FLL : ctrl1.clock_source_select;

   fcss_edge_div #(
      .NSRC  (NSRC),
      .SEL_W (2),
      .DIV_W (2)
   ) u_sys_div (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .src_edge   (src_edge),
      .sel_req    (sys_sel),
      .div_req    (ctrl2.bus_divider_select),
      .hold_req   (in_stop),
      .clk_out    (clock_output),
      .sel_active (sys_sel_active),
      .div_active (sys_div_active),
      .held       (sys_held)
   );

   // =========================================================
   // Bus clock and debug clock
   // Debug clock only parks when low, so its last pulse is whole
   assign debug_on = fll_enable && !in_stop;

   always_comb begin
      next_out_q     = clock_output;
      next_bus_clock = bus_clock;
      if (clock_output && !out_q) begin
         next_bus_clock = !bus_clock;
      end
      next_debug_clock = debug_clock;
      if (src_edge[SRC_FLL] && dco_clk && (debug_on || debug_clock)) begin
         next_debug_clock = !debug_clock;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_q       <= 1'h0;
         bus_clock   <= 1'h0;
         debug_clock <= 1'h0;
      end else begin
         out_q       <= next_out_q;
         bus_clock   <= next_bus_clock;
         debug_clock <= next_debug_clock;
      end
   end

endmodule : fcss_clock_source

/* File: tb/fcss_sva.sv */
/*
 Port checker for the clock source selector, bound to its top.
 Assumes one hclk domain; hresetn and power_on_resetn are asynchronous.
*/
`timescale 1ns/1ps
module fcss_sva (
   input wire logic                     hclk,
   input wire logic                     hresetn,
   input wire logic                     power_on_resetn,
   input wire logic                     dco_clk,
   input wire logic                     stop_request,
   input wire logic                     clock_output,
   input wire logic                     bus_clock,
   input wire logic                     debug_clock,
   input wire logic                     fll_enable,
   input wire logic [8:0]               trim_value,
   input wire logic                     internal_ref_on,
   input wire fcss_pkg::fcss_osc_ctrl_t osc_ctrl
);
   import fcss_pkg::*;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ==========
   // Assertions
   bus_half_a: assert property (
      $rose(clock_output) |-> ##[0:1] $changed(bus_clock))
      else $error("bus clock missed a rising output edge");
   reset_mode_a: assert property (disable iff (1'b0)
      !hresetn |-> fll_enable && internal_ref_on && !clock_output
      && !bus_clock && !debug_clock && osc_ctrl == '0)
      else $error("reset state wrong");
   por_trim_a: assert property (disable iff (1'b0)
      !power_on_resetn |-> trim_value == {COARSE_TRIM_POR, FINE_TRIM_POR})
      else $error("power-on trim wrong");
   trim_keep_a: assert property (disable iff (!power_on_resetn)
      !hresetn |-> $stable(trim_value))
      else $error("trim lost in reset");
   dbg_source_a: assert property (
      $rose(debug_clock) |-> $past(dco_clk) || $past(dco_clk, 2))
      else $error("debug clock rose without dco");
   dbg_off_a: assert property (
      (!fll_enable && !debug_clock) ##1 !fll_enable |=> !debug_clock)
      else $error("debug clock runs with fll off");
   stop_quiet_a: assert property (
      stop_request [*8] |-> !fll_enable && !debug_clock)
      else $error("clocks alive in stop");
   no_glitch_a: assert property (
      $changed(clock_output) |=> $stable(clock_output))
      else $error("one-cycle output pulse");
   cover property ($rose(bus_clock));
   cover property ($rose(debug_clock));
   cover property (stop_request && !fll_enable);
endmodule : fcss_sva

bind fcss_clock_source fcss_sva u_sva (
   .hclk(hclk), .hresetn(hresetn), .power_on_resetn(power_on_resetn),
   .dco_clk(dco_clk), .stop_request(stop_request),
   .clock_output(clock_output), .bus_clock(bus_clock),
   .debug_clock(debug_clock), .fll_enable(fll_enable),
   .trim_value(trim_value), .internal_ref_on(internal_ref_on),
   .osc_ctrl(osc_ctrl));

/* File: tb/fcss_partner.sv */
/*
 Far-side model: digital oscillator, both references and the oscillator.
 Assumes sources change on rising hclk, each half period >= 2 cycles.
*/
`timescale 1ns/1ps
module fcss_partner #(
   parameter int DHP = 2,
   parameter int IHP = 5,
   parameter int EHP = 3
) (
   input  wire logic                     hclk,
   input  wire fcss_pkg::fcss_osc_ctrl_t osc_ctrl,
   output logic                          dco_clk,
   output logic                          int_ref_clk,
   output logic                          ext_ref_clk,
   output logic                          oscillator_ready
);
   import fcss_pkg::*;
   int n = 0;
   int up = 0;
   always @(posedge hclk) begin
      n <= n + 1;
      dco_clk <= (n / DHP) % 2 != 0;
      int_ref_clk <= (n / IHP) % 2 != 0;
      // Stands still unless enabled, as a real source would
      ext_ref_clk <= osc_ctrl.external_ref_enable && (n / EHP) % 2 != 0;
      // Start-up delay after request
      up <= osc_ctrl.oscillator_request ? up + 1 : 0;
      oscillator_ready <= up >= 20;
   end
endmodule : fcss_partner

/* File: tb/tb_top.sv */
/*
 Testbench top: resets, register traffic, mode and divider sweep, stop.
 Assumes the partner model drives the source clocks.
*/
`timescale 1ns/1ps
module tb_top;
   import fcss_pkg::*;
   localparam int DHP = 2;
   localparam int IHP = 5;
   localparam int EHP = 3;
   logic           hclk = 1'b0;
   logic           hresetn = 1'b1;
   logic           power_on_resetn = 1'b1;
   logic           hsel = 1'b0;
   logic           hwrite = 1'b0;
   logic           stop_request = 1'b0;
   logic           debug_active = 1'b0;
   logic [1:0]     htrans = 2'h0;
   logic [2:0]     hsize = 3'h2;
   logic [31:0]    haddr = 32'h0;
   logic [31:0]    hwdata = 32'h0;
   logic [31:0]    rd;
   logic           hreadyout, hresp, dco_clk, int_ref_clk, ext_ref_clk;
   logic           oscillator_ready, clock_output, bus_clock, debug_clock;
   logic           fll_enable, fll_reference_clock, internal_ref_on;
   logic [31:0]    hrdata;
   logic [8:0]     trim_value;
   fcss_osc_ctrl_t osc_ctrl;
   int             mismatches = 0;
   int             n_tests = 0;
   initial forever #10 hclk = ~hclk;
   fcss_clock_source uut (.hclk(hclk), .hresetn(hresetn),
      .power_on_resetn(power_on_resetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .dco_clk(dco_clk), .int_ref_clk(int_ref_clk),
      .ext_ref_clk(ext_ref_clk), .stop_request(stop_request),
      .debug_active(debug_active), .oscillator_ready(oscillator_ready),
      .clock_output(clock_output), .bus_clock(bus_clock),
      .debug_clock(debug_clock), .fll_enable(fll_enable),
      .fll_reference_clock(fll_reference_clock), .trim_value(trim_value),
      .internal_ref_on(internal_ref_on), .osc_ctrl(osc_ctrl));
   fcss_partner #(.DHP(DHP), .IHP(IHP), .EHP(EHP)) far (.hclk(hclk),
      .osc_ctrl(osc_ctrl), .dco_clk(dco_clk), .int_ref_clk(int_ref_clk),
      .ext_ref_clk(ext_ref_clk), .oscillator_ready(oscillator_ready));
   // ==========
   // Helpers
   task automatic tally_and_finish;
      if (mismatches == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic near(input int seen, input int exp);
      check(seen >= exp - 1 && seen <= exp + 1, 1'b1);
   endtask : near
   task automatic ahb(input logic w, input logic [3:0] a,
                      input logic [31:0] d, input logic [2:0] sz);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {28'h0, a};
      hwrite <= w;
      hsize <= sz;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      #1;
   endtask : ahb
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      ahb(1'b1, a, d, HSIZE_WORD);
   endtask : wr
   task automatic rdc(input logic [3:0] a, input logic [31:0] e,
                      input logic [7:0] m);
      ahb(1'b0, a, 32'h0, HSIZE_WORD);
      check(rd & {24'h0, m}, e);
   endtask : rdc
   task automatic meas(output int n[4]);
      logic [3:0] p, v;
      n = '{default: 0};
      @(negedge hclk);
      v = {clock_output, bus_clock, debug_clock, fll_reference_clock};
      repeat (256) begin
         @(negedge hclk);
         p = v;
         v = {clock_output, bus_clock, debug_clock, fll_reference_clock};
         foreach (n[k]) n[k] += int'(v[k] && !p[k]);
      end
      @(posedge hclk);
   endtask : meas
   function automatic int hp(input logic [1:0] s);
      return s == SRC_INT ? IHP : s == SRC_EXT ? EHP : DHP;
   endfunction : hp
   // ==========
   // Sequence
   initial begin
      repeat (30000) @(posedge hclk);
      mismatches++;
      tally_and_finish();
   end
   initial begin
      int n[4], q;
      logic [1:0] src, bd;
      logic [2:0] r;
      logic [7:0] t;
      logic lp, en, f;
      void'($urandom(29));
      hresetn <= 1'b0;
      power_on_resetn <= 1'b0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      power_on_resetn <= 1'b1;
      rdc(OFS_CTRL1, CTRL1_RESET, 8'hff);
      rdc(OFS_CTRL2, CTRL2_RESET, 8'hff);
      rdc(OFS_TRIM, COARSE_TRIM_POR, 8'hff);
      rdc(OFS_STATUS, FINE_TRIM_POR, 8'he1);
      t = 8'($urandom);
      f = 1'($urandom);
      wr(OFS_TRIM, t);
      wr(OFS_STATUS, {8'hfe, f});
      check(trim_value, {t, f});
      rdc(OFS_STATUS, f, 8'he1);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      check(trim_value, {t, f});
      rdc(OFS_TRIM, t, 8'hff);
      ahb(1'b1, OFS_CTRL1, 32'hff, 3'h0);
      rdc(OFS_CTRL1, CTRL1_RESET, 8'hff);
      for (int i = 0; i < 16; i++) begin
         src = 2'(i);
         bd = 2'(i >> 2);
         lp = 1'($urandom);
         r = 3'($urandom);
         debug_active <= 1'($urandom);
         wr(OFS_CTRL1, {src, 2'h0, r[1], r[0], 2'h2});
         wr(OFS_CTRL2, {bd, r[2:1], lp, 3'h6});
         repeat (300) @(posedge hclk);
         meas(n);
         en = (src == SRC_INT || src == SRC_EXT) ? !lp || debug_active : 1;
         check(fll_enable, en);
         check(n[1] > 0, en);
         near(n[3], 256 / (2 * hp(src) << bd));
         near(n[2], n[3] / 2);
         q = r[0] ? IHP : EHP;
         near(n[0], en ? 256 / (2 * q << r[1]) : 0);
         if (src == SRC_RSVD) src = SRC_FLL;
         rdc(OFS_STATUS, {r[0], src, 2'h2}, 8'h1e);
         check(osc_ctrl, {r[1], r[2], 3'h6});
      end
      stop_request <= 1'b1;
      repeat (300) @(posedge hclk);
      meas(n);
      q = n[3] + n[1] + n[0];
      check({fll_enable, q != 0, osc_ctrl[1]}, 3'h0);
      stop_request <= 1'b0;
      hresetn <= 1'b0;
      power_on_resetn <= 1'b0;
      repeat (3) @(posedge hclk);
      check(trim_value, {COARSE_TRIM_POR, FINE_TRIM_POR});
      tally_and_finish();
   end
endmodule : tb_top
